// ### core/vdm_limit_check.v
// four-threshold crossing detector for one value
`timescale 1ns/1ns
module vdm_limit_check (
    input wire [15:0] value,
    input wire is_signed,
    input wire [15:0] thr_ha,
    input wire [15:0] thr_la,
    input wire [15:0] thr_hw,
    input wire [15:0] thr_lw,
    output reg [3:0] flags
);
`include "vdm_map.vh"
    // flipping the sign bit turns a signed compare into an unsigned one
    wire [15:0] flip = {is_signed, 15'h0000};
    wire [15:0] v = value ^ flip;
    always @* begin
        flags = 4'h0;
        flags[`FLG_HA] = v > (thr_ha ^ flip);
        flags[`FLG_LA] = v < (thr_la ^ flip);
        flags[`FLG_HW] = v > (thr_hw ^ flip);
        flags[`FLG_LW] = v < (thr_lw ^ flip);
    end
endmodule // vdm_limit_check

// ### core/vdm_map.vh
// offsets, field positions, reset values and codes of the diagnostic monitor pages
// ****************************************************************
// Summary of operation
// - Monitor feature is optional; presence shown by a dedicated advertisement bit.
// - Up to 256 monitor slots, each tracking one observable.
// - Slot data lives in paged range 20h-2Fh, grouped by 64 slots.
// - Basic observables give a readable recent sample and threshold crossing detection.
// - Some observables get interval statistics: minimum, maximum and average.
// - A slot is active on a basic observable or statistic, or passive.
// - Read-only descriptors over four pages, 64 per page, two bytes each.
// - Descriptor picks a four-threshold set used to detect crossings and set flags.
// - Host-set mask bits keep their flags out of interrupt request generation.
// - Basic slots periodically get a two-byte sample in read-only sample pages.
// - Statistics read live; host freeze stops their update for consistent reads.
// - Threshold crossing detection also runs on statistic observables.
// - Global freeze resets internal statistics at the last register update.
// - Read-only threshold pages hold 16 sets of four two-byte thresholds each.
// - Latched flags packed two slots per byte, read-only, cleared on read.
// - Read-write mask bytes, four bits per slot, every bit resets to 1.
// - One page mixes read-only support details and read-write dynamic controls.
// - Modules with more than 8 lanes may add slots in further banks.
// - Descriptor even byte bits 7-4: local set number plus group base.
// - Even byte bits 3-0: resource 0-7 lane or data path, 15 module.
// - Multi-byte monitor values are stored most significant byte first.
// ****************************************************************
`ifndef VDM_MAP_VH
`define VDM_MAP_VH

`define SLOTS 256
// page nibble is page number minus 20h
`define FAM_DESC 2'h0
`define FAM_SAMP 2'h1
`define FAM_THR 2'h2
`define FAM_MISC 2'h3
`define PG_FLAG 2'h0
`define PG_MASK 2'h1
`define PG_RSVD 2'h2
`define PG_CTRL 2'h3
// control page bytes, offset from byte 128
`define CTRL_SUPPORT 7'h00
`define CTRL_FREEZE 7'h01
`define CTRL_STATUS 7'h02
`define FRZ_BIT 0
// descriptor as a 16-bit word, even byte on top
`define DESC_SET_HI 15
`define DESC_SET_LO 12
`define DESC_RES_HI 11
`define DESC_RES_LO 8
`define RES_LANE_MAX 4'h7
`define RES_MODULE 4'hF
// observable type codes
`define TYPE_UNUSED 8'h00
`define TYPE_TEC 8'h02
`define TYPE_FREQ 8'h03
`define TYPE_LTEMP 8'h04
`define TYPE_MIN_MEDIA 8'h09
`define TYPE_MIN_HOST 8'h0A
`define TYPE_MAX_MEDIA 8'h0B
`define TYPE_MAX_HOST 8'h0C
`define TYPE_AVG_MEDIA 8'h0D
`define TYPE_AVG_HOST 8'h0E
// statistic kinds
`define KIND_MIN 2'h1
`define KIND_MAX 2'h2
`define KIND_AVG 2'h3
// flag bit positions
`define FLG_HA 3
`define FLG_LA 2
`define FLG_HW 1
`define FLG_LW 0
`define MASK_RST 4'hF
`define SAMP_RST 16'h0000
`define MIN_INIT 16'hFFFF
`define MAX_INIT 16'h0000
`define SUPPORT_VAL 8'h03
// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RESP_DECERR 2'b11

`endif

// ### core/vdm_pages.v
// diagnostic monitor slot pages behind an AXI4-Lite slave
`timescale 1ns/1ns
module vdm_pages (
    input wire REF_CLK,
    input wire ARST_N,
    input wire [15:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [15:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire SMP_VALID,
    input wire [7:0] SMP_SLOT,
    input wire [15:0] SMP_DATA,
    input wire LD_VALID,
    input wire LD_THR,
    input wire [7:0] LD_INDEX,
    input wire [15:0] LD_DATA,
    output reg VDM_SUPPORTED,
    output reg VDM_IRQ_REQ
);
`include "vdm_map.vh"

// ****************************************************************
// helpers
// ****************************************************************
    function [1:0] stat_kind;
        input [7:0] t;
        begin
            case (t)
                `TYPE_MIN_MEDIA, `TYPE_MIN_HOST: stat_kind = `KIND_MIN;
                `TYPE_MAX_MEDIA, `TYPE_MAX_HOST: stat_kind = `KIND_MAX;
                `TYPE_AVG_MEDIA, `TYPE_AVG_HOST: stat_kind = `KIND_AVG;
                default: stat_kind = 2'h0;
            endcase
        end
    endfunction

    function [15:0] stat_init;
        input [7:0] t;
        begin
            if (stat_kind(t) == `KIND_MIN)
                stat_init = `MIN_INIT;
            else
                stat_init = `MAX_INIT;
        end
    endfunction

    function res_ok;
        input [3:0] r;
        begin
            res_ok = (r <= `RES_LANE_MAX) || (r == `RES_MODULE);
        end
    endfunction

    function [7:0] pick_byte;
        input [15:0] w;
        input lo;
        begin
            pick_byte = lo ? w[7:0] : w[15:8];
        end
    endfunction

// ****************************************************************
// reset release
// ****************************************************************
    // asserts at once, releases on an edge so no flop leaves reset mid-cycle
    reg rst_ff1_r;
    reg rst_n_r;
    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_ff1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_ff1_r <= 1'b1;
            rst_n_r <= rst_ff1_r;
        end
    end

// ****************************************************************
// storage
// ****************************************************************
    // all tables in flops: costly, but every byte reads back in the take cycle
    reg [15:0] desc_r [0:`SLOTS-1];
    reg [15:0] thr_r [0:`SLOTS-1];
    reg [15:0] samp_r [0:`SLOTS-1];
    reg [15:0] acc_r [0:`SLOTS-1];
    reg [3:0] flag_r [0:`SLOTS-1];
    reg [3:0] mask_r [0:`SLOTS-1];
    reg freeze_r;
    integer i;
    integer j;

// ****************************************************************
// sample path
// ****************************************************************
    wire [15:0] sd = desc_r[SMP_SLOT];
    wire [7:0] styp = sd[7:0];
    wire [1:0] skind = stat_kind(styp);
    // group base plus local set number
    wire [5:0] gset = {SMP_SLOT[7:6], sd[`DESC_SET_HI:`DESC_SET_LO]};
    wire smp_ok = SMP_VALID && (styp != `TYPE_UNUSED) && res_ok(sd[`DESC_RES_HI:`DESC_RES_LO]);
    wire smp_stat = (skind != 2'h0);
    wire is_sgn = (styp == `TYPE_TEC) || (styp == `TYPE_FREQ) || (styp == `TYPE_LTEMP);
    wire [15:0] acc_nxt;
    wire [3:0] new_flags;

    vdm_stat_step u_stat (
        .kind(skind),
        .acc(acc_r[SMP_SLOT]),
        .smp(SMP_DATA),
        .acc_nxt(acc_nxt)
    );

    // statistic slots are judged on the new statistic, not on the raw sample
    vdm_limit_check u_limit (
        .value(smp_stat ? acc_nxt : SMP_DATA),
        .is_signed(is_sgn),
        .thr_ha(thr_r[{gset, 2'd0}]),
        .thr_la(thr_r[{gset, 2'd1}]),
        .thr_hw(thr_r[{gset, 2'd2}]),
        .thr_lw(thr_r[{gset, 2'd3}]),
        .flags(new_flags)
    );

// ****************************************************************
// bus write side
// ****************************************************************
    reg aw_held_r;
    reg w_held_r;
    reg [15:0] aw_addr_r;
    reg [7:0] w_byte_r;
    reg w_strb0_r;
    wire do_wr = aw_held_r && w_held_r && !S_AXI_BVALID;
    // bank field beyond bank 0 is not populated: only 8 lanes here
    wire [2:0] wr_bank = aw_addr_r[15:13];
    wire [3:0] wr_pg = aw_addr_r[12:9];
    wire [6:0] wr_off = aw_addr_r[8:2];
    wire wr_mask = (wr_bank == 3'd0) && (wr_pg == {`FAM_MISC, `PG_MASK});
    wire wr_ctrl = (wr_bank == 3'd0) && (wr_pg == {`FAM_MISC, `PG_CTRL}) && (wr_off == `CTRL_FREEZE);
    wire frz_val = w_byte_r[`FRZ_BIT];
    wire frz_start = do_wr && w_strb0_r && wr_ctrl && frz_val && !freeze_r;

    // ready drops after each take, so a held channel is never overwritten
    always @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 16'h0000;
            w_byte_r <= 8'h00;
            w_strb0_r <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= !aw_held_r && !(S_AXI_AWVALID && S_AXI_AWREADY);
            S_AXI_WREADY <= !w_held_r && !(S_AXI_WVALID && S_AXI_WREADY);
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_r <= 1'b1;
                w_byte_r <= S_AXI_WDATA[7:0];
                w_strb0_r <= S_AXI_WSTRB[0];
            end
            if (do_wr) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                if (wr_bank != 3'd0)
                    S_AXI_BRESP <= `RESP_DECERR;
                else
                    S_AXI_BRESP <= `RESP_OKAY;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

// ****************************************************************
// bus read side
// ****************************************************************
    wire rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
    wire [2:0] rd_bank = S_AXI_ARADDR[15:13];
    wire [3:0] rd_pg = S_AXI_ARADDR[12:9];
    wire [6:0] rd_off = S_AXI_ARADDR[8:2];
    wire [7:0] rd_slot = {rd_pg[1:0], rd_off[6:1]};
    wire [7:0] pair_lo = {rd_off, 1'b0};
    wire [7:0] pair_hi = {rd_off, 1'b1};
    reg [7:0] rd_byte;
    reg [1:0] rd_resp;
    reg rd_clr;
    reg any_irq;

    // unused bytes and the reserved page read as zero with an OKAY answer
    always @* begin
        rd_byte = 8'h00;
        rd_resp = `RESP_OKAY;
        rd_clr = 1'b0;
        if (rd_bank != 3'd0) begin
            rd_resp = `RESP_DECERR;
        end else begin
            case (rd_pg[3:2])
                `FAM_DESC: rd_byte = pick_byte(desc_r[rd_slot], rd_off[0]);
                `FAM_SAMP: rd_byte = pick_byte(samp_r[rd_slot], rd_off[0]);
                `FAM_THR: rd_byte = pick_byte(thr_r[rd_slot], rd_off[0]);
                default: begin
                    case (rd_pg[1:0])
                        `PG_FLAG: begin
                            rd_byte = {flag_r[pair_hi], flag_r[pair_lo]};
                            rd_clr = rd_take;
                        end
                        `PG_MASK: rd_byte = {mask_r[pair_hi], mask_r[pair_lo]};
                        `PG_CTRL: begin
                            case (rd_off)
                                `CTRL_SUPPORT: rd_byte = `SUPPORT_VAL;
                                `CTRL_FREEZE: rd_byte = {7'h00, freeze_r};
                                `CTRL_STATUS: rd_byte = {6'h00, VDM_IRQ_REQ, freeze_r};
                                default: rd_byte = 8'h00;
                            endcase
                        end
                        default: rd_byte = 8'h00;
                    endcase
                end
            endcase
        end
    end

    // byte captured at the take edge, before that edge's flag clear lands
    always @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !rd_take;
            if (rd_take) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= {24'h00_0000, rd_byte};
                S_AXI_RRESP <= rd_resp;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

// ****************************************************************
// slot state
// ****************************************************************
    wire hit_lo = rd_clr && (SMP_SLOT == pair_lo);
    wire hit_hi = rd_clr && (SMP_SLOT == pair_hi);

    always @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            for (i = 0; i < `SLOTS; i = i + 1) begin
                desc_r[i] <= 16'h0000;
                thr_r[i] <= 16'h0000;
                samp_r[i] <= `SAMP_RST;
                acc_r[i] <= `MAX_INIT;
                flag_r[i] <= 4'h0;
                mask_r[i] <= `MASK_RST;
            end
            freeze_r <= 1'b0;
        end else begin
            if (LD_VALID && !LD_THR) begin
                desc_r[LD_INDEX] <= LD_DATA;
                // a rebound slot starts its statistic from the kind's neutral value
                acc_r[LD_INDEX] <= stat_init(LD_DATA[7:0]);
            end
            if (LD_VALID && LD_THR)
                thr_r[LD_INDEX] <= LD_DATA;
            if (do_wr && w_strb0_r && wr_ctrl)
                freeze_r <= frz_val;
            if (do_wr && w_strb0_r && wr_mask) begin
                mask_r[{wr_off, 1'b0}] <= w_byte_r[3:0];
                mask_r[{wr_off, 1'b1}] <= w_byte_r[7:4];
            end
            // freeze entry: every statistic register gets its last value and its accumulator restarts together
            if (frz_start) begin
                for (i = 0; i < `SLOTS; i = i + 1) begin
                    if (stat_kind(desc_r[i][7:0]) != 2'h0) begin
                        samp_r[i] <= acc_r[i];
                        acc_r[i] <= stat_init(desc_r[i][7:0]);
                    end
                end
            end
            // clear on read lands at the read's take edge
            if (rd_clr) begin
                flag_r[pair_lo] <= 4'h0;
                flag_r[pair_hi] <= 4'h0;
            end
            if (smp_ok) begin
                // a crossing seen while its byte is being read survives the clear
                flag_r[SMP_SLOT] <= ((hit_lo || hit_hi) ? 4'h0 : flag_r[SMP_SLOT]) | new_flags;
                if (!smp_stat) begin
                    samp_r[SMP_SLOT] <= SMP_DATA;
                end else if (frz_start) begin
                    samp_r[SMP_SLOT] <= acc_nxt;
                    acc_r[SMP_SLOT] <= stat_init(styp);
                end else begin
                    acc_r[SMP_SLOT] <= acc_nxt;
                    if (!freeze_r)
                        samp_r[SMP_SLOT] <= acc_nxt;
                end
            end
        end
    end

// ****************************************************************
// interrupt request and advertisement
// ****************************************************************
    // wide or over all slots, registered below so the request never glitches
    always @* begin
        any_irq = 1'b0;
        for (j = 0; j < `SLOTS; j = j + 1)
            any_irq = any_irq | (|(flag_r[j] & ~mask_r[j]));
    end

    always @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            VDM_SUPPORTED <= 1'b0;
            VDM_IRQ_REQ <= 1'b0;
        end else begin
            VDM_SUPPORTED <= 1'b1;
            VDM_IRQ_REQ <= any_irq;
        end
    end
endmodule // vdm_pages

// ### core/vdm_stat_step.v
// one statistics update step: min, max or running average
`timescale 1ns/1ns
module vdm_stat_step (
    input wire [1:0] kind,
    input wire [15:0] acc,
    input wire [15:0] smp,
    output reg [15:0] acc_nxt
);
`include "vdm_map.vh"
    // average is a halving mean; no per-slot sample count kept, to save flops
    wire [16:0] sum = {1'b0, acc} + {1'b0, smp};
    always @* begin
        case (kind)
            `KIND_MIN: acc_nxt = (smp < acc) ? smp : acc;
            `KIND_MAX: acc_nxt = (smp > acc) ? smp : acc;
            `KIND_AVG: acc_nxt = sum[16:1];
            default: acc_nxt = smp;
        endcase
    end
endmodule // vdm_stat_step

// ### test/vdm_host.sv
// host master model: one write and one read at a time
`timescale 1ns/1ns
module vdm_host (
    input wire clk,
    output logic [15:0] awaddr,
    output logic awvalid,
    input wire awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire wready,
    input wire [1:0] bresp,
    input wire bvalid,
    output logic bready,
    output logic [15:0] araddr,
    output logic arvalid,
    input wire arready,
    input wire [31:0] rdata,
    input wire [1:0] rresp,
    input wire rvalid,
    output logic rready
);
    localparam int LIMIT = 200;
    // ****************
    // bus cycles
    // ****************
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        wstrb = 4'h1;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r, output bit to);
        int n;
        bit aw;
        bit w;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        aw = 0;
        w = 0;
        n = 0;
        // each channel released at its own take edge
        while (!(aw && w) && n < LIMIT) begin
            @(posedge clk);
            n++;
            if (awvalid && awready) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        // answer ready raised late so the slave must hold its response
        repeat (2) @(posedge clk);
        n += 2;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (!bvalid && n < LIMIT);
        r = bresp;
        bready <= 1'b0;
        to = n >= LIMIT;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r, output bit to);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!arready && n < LIMIT);
        arvalid <= 1'b0;
        @(posedge clk);
        n++;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (!rvalid && n < LIMIT);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        to = n >= LIMIT;
    endtask
endmodule // vdm_host

// ### test/vdm_pages_props.sv
// concurrent checks on the ports of the monitor page slave
`timescale 1ns/1ns
`include "vdm_map.vh"
module vdm_pages_props (
    input logic REF_CLK,
    input logic ARST_N,
    input logic [15:0] S_AXI_AWADDR,
    input logic S_AXI_AWVALID,
    input logic S_AXI_AWREADY,
    input logic S_AXI_WVALID,
    input logic S_AXI_WREADY,
    input logic [1:0] S_AXI_BRESP,
    input logic S_AXI_BVALID,
    input logic S_AXI_BREADY,
    input logic [15:0] S_AXI_ARADDR,
    input logic S_AXI_ARVALID,
    input logic S_AXI_ARREADY,
    input logic [31:0] S_AXI_RDATA,
    input logic [1:0] S_AXI_RRESP,
    input logic S_AXI_RVALID,
    input logic S_AXI_RREADY,
    input logic VDM_SUPPORTED
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    // ****************
    // bus steps
    // ****************
    sequence s_wtake; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY; endsequence
    sequence s_rtake; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
    property p_b_lat; s_wtake |-> ##1 !S_AXI_BVALID ##1 S_AXI_BVALID; endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late or early");
    property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_w_dec; s_wtake ##0 S_AXI_AWADDR[15:13] != 3'h0 |-> ##2 S_AXI_BRESP == `RESP_DECERR; endproperty
    a_w_dec: assert property (p_w_dec) else $error("foreign bank write not refused");
    property p_r_lat; s_rtake |=> S_AXI_RVALID && !S_AXI_ARREADY; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data moved");
    property p_r_dec; s_rtake ##0 S_AXI_ARADDR[15:13] != 3'h0 |=> S_AXI_RRESP == `RESP_DECERR; endproperty
    a_r_dec: assert property (p_r_dec) else $error("foreign bank read not refused");
    property p_r_byte; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0; endproperty
    a_r_byte: assert property (p_r_byte) else $error("read word wider than a byte");
    property p_supp; S_AXI_ARREADY |-> VDM_SUPPORTED; endproperty
    a_supp: assert property (p_supp) else $error("feature presence not shown");
    property p_sup_val; s_rtake ##0 S_AXI_ARADDR == 16'h1E00 |=> S_AXI_RDATA[7:0] == `SUPPORT_VAL; endproperty
    a_sup_val: assert property (p_sup_val) else $error("support byte wrong");
endmodule // vdm_pages_props
bind vdm_pages vdm_pages_props i_props (.*);

// ### test/vdm_pages_tb.sv
// self-checking bench for the monitor page slave
`timescale 1ns/1ns
`include "vdm_map.vh"
module vdm_pages_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic smp_valid = 1'b0;
    logic [7:0] smp_slot = 8'h00;
    logic [15:0] smp_data = 16'h0000;
    logic ld_valid = 1'b0;
    logic ld_thr = 1'b0;
    logic [7:0] ld_index = 8'h00;
    logic [15:0] ld_data = 16'h0000;
    logic [15:0] thr [4] = '{16'h0100, 16'hFF00, 16'h0080, 16'hFF80};
    wire [15:0] awaddr, araddr;
    wire [31:0] wdata, rdata;
    wire [3:0] wstrb;
    wire [1:0] bresp, rresp;
    wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, supported, irq;
    int failures = 0;
    int tests_run = 0;
    always #5 clk = ~clk;
    vdm_host i_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    vdm_pages i_dut (.REF_CLK(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SMP_VALID(smp_valid),
        .SMP_SLOT(smp_slot), .SMP_DATA(smp_data), .LD_VALID(ld_valid), .LD_THR(ld_thr),
        .LD_INDEX(ld_index), .LD_DATA(ld_data), .VDM_SUPPORTED(supported), .VDM_IRQ_REQ(irq));
    // ****************
    // helpers
    // ****************
    task automatic end_sim;
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hung(input bit to);
        if (to) begin
            failures++;
            $display("ERROR %0t: bus wait ran out", $time);
            end_sim();
        end
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        bit to;
        i_host.rd(a, d, r, to);
        hung(to);
        chk(d, {24'h0, e});
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic wrc(input logic [15:0] a, input logic [7:0] v, input logic [1:0] er);
        logic [1:0] r;
        bit to;
        i_host.wr(a, v, r, to);
        hung(to);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic smp(input logic [7:0] s, input logic [15:0] v);
        @(posedge clk);
        smp_valid <= 1'b1;
        smp_slot <= s;
        smp_data <= v;
        @(posedge clk);
        smp_valid <= 1'b0;
    endtask
    task automatic ld(input logic t, input logic [7:0] i, input logic [15:0] v);
        @(posedge clk);
        ld_valid <= 1'b1;
        ld_thr <= t;
        ld_index <= i;
        ld_data <= v;
        @(posedge clk);
        ld_valid <= 1'b0;
    endtask
    // ****************
    // scenarios
    // ****************
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({31'h0, supported}, 32'h1);
        rdc(16'h1E00, `SUPPORT_VAL, `RESP_OKAY);
        rdc(16'h1A00, 8'hFF, `RESP_OKAY);
        rdc(16'h1BFC, 8'hFF, `RESP_OKAY);
        rdc(16'h1800, 8'h00, `RESP_OKAY);
        // slot 0 signed on the module, slot 1 max statistic on lane 0, both on set 1
        ld(1'b0, 8'd0, 16'h1F02);
        ld(1'b0, 8'd1, 16'h100B);
        for (int k = 0; k < 4; k++) ld(1'b1, 8'(4 + k), thr[k]);
        rdc(16'h0000, 8'h1F, `RESP_OKAY);
        rdc(16'h0004, 8'h02, `RESP_OKAY);
        rdc(16'h1020, 8'h01, `RESP_OKAY);
        rdc(16'h1028, 8'hFF, `RESP_OKAY);
        wrc(16'h0000, 8'h55, `RESP_OKAY);
        rdc(16'h0000, 8'h1F, `RESP_OKAY);
        smp(8'd0, 16'h0090);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rdc(16'h0800, 8'h00, `RESP_OKAY);
        rdc(16'h0804, 8'h90, `RESP_OKAY);
        wrc(16'h1A00, 8'hFD, `RESP_OKAY);
        rdc(16'h1A00, 8'hFD, `RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        rdc(16'h1800, 8'h02, `RESP_OKAY);
        rdc(16'h1800, 8'h00, `RESP_OKAY);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        smp(8'd0, 16'hFE00);
        rdc(16'h1800, 8'h05, `RESP_OKAY);
        smp(8'd2, 16'h1234);
        rdc(16'h0810, 8'h00, `RESP_OKAY);
        smp(8'd1, 16'h0010);
        smp(8'd1, 16'h0050);
        smp(8'd1, 16'h0030);
        rdc(16'h080C, 8'h50, `RESP_OKAY);
        rdc(16'h1800, 8'h50, `RESP_OKAY);
        wrc(16'h1E04, 8'h01, `RESP_OKAY);
        rdc(16'h1E08, 8'h01, `RESP_OKAY);
        smp(8'd1, 16'h0020);
        rdc(16'h080C, 8'h50, `RESP_OKAY);
        wrc(16'h1E04, 8'h00, `RESP_OKAY);
        smp(8'd1, 16'h0020);
        rdc(16'h080C, 8'h20, `RESP_OKAY);
        // slot 3 minimum, slot 4 average, both on set 1
        ld(1'b0, 8'd3, 16'h1009);
        ld(1'b0, 8'd4, 16'h100D);
        smp(8'd3, 16'h0040);
        smp(8'd3, 16'h0030);
        smp(8'd4, 16'h0040);
        smp(8'd4, 16'h0040);
        rdc(16'h081C, 8'h30, `RESP_OKAY);
        rdc(16'h0824, 8'h30, `RESP_OKAY);
        // foreign bank and reserved page
        rdc(16'h2000, 8'h00, `RESP_DECERR);
        wrc(16'h3A00, 8'h00, `RESP_DECERR);
        i_host.wstrb <= 4'h0;
        wrc(16'h1A00, 8'h00, `RESP_OKAY);
        i_host.wstrb <= 4'h1;
        rdc(16'h1A00, 8'hFD, `RESP_OKAY);
        rdc(16'h1C00, 8'h00, `RESP_OKAY);
        end_sim();
    end
endmodule // vdm_pages_tb
